// file: common/mesmq_link_if.sv
// mesmq_link_if: signals between the top and its two helper modules
`timescale 1ns/1ns
`default_nettype none
interface mesmq_link_if;
    logic sector_start;
    logic [2:0] mark_thr;
    logic [2:0] space_thr;
    logic sm_cand;
    logic long_mark_pin;
    logic long_space_pin;
    logic sm_qualified;
    logic cc_set;
    logic cc_clr;
    logic cc_auto;
    logic cc_flush;
    logic cc_bit;

    modport top (
        output sector_start, mark_thr, space_thr, sm_cand,
        output long_mark_pin, long_space_pin,
        output cc_set, cc_clr, cc_auto, cc_flush,
        input sm_qualified, cc_bit
    );
    modport qual (
        input sector_start, mark_thr, space_thr, sm_cand,
        input long_mark_pin, long_space_pin,
        output sm_qualified
    );
    modport cc (
        input cc_set, cc_clr, cc_auto, cc_flush,
        output cc_bit
    );
endinterface : mesmq_link_if
`default_nettype wire

// file: common/mesmq_pkg.sv
// mesmq_pkg: offsets, field positions, reset values and limits of the block
package mesmq_pkg;

    // ****
    // register offsets on the microcontroller port
    // ****
    localparam logic [7:0] MESMQ_ADDR_MEDIA_ERR = 8'h23;
    localparam logic [7:0] MESMQ_ADDR_SM_CTRL = 8'h24;

    // ****
    // media error flag positions
    // ****
    localparam int MESMQ_BIT_DSYNC_RECOV = 4;
    localparam int MESMQ_BIT_DSYNC_FATAL = 3;
    localparam int MESMQ_BIT_RESYNC_THR = 2;
    localparam int MESMQ_BIT_FLAG_FIELD = 1;
    localparam int MESMQ_BIT_CC_BLANK = 0;
    localparam int MESMQ_FLAG_W = 5;
    localparam logic [4:0] MESMQ_FLAGS_RST = 5'h00;

    // ****
    // sector mark control fields
    // ****
    localparam int MESMQ_WPOS_HI = 7;
    localparam int MESMQ_WPOS_LO = 6;
    localparam int MESMQ_MTHR_HI = 5;
    localparam int MESMQ_MTHR_LO = 3;
    localparam int MESMQ_STHR_HI = 2;
    localparam int MESMQ_STHR_LO = 0;
    // delayed window, three long marks, three long spaces
    localparam logic [7:0] MESMQ_SM_CTRL_RST = 8'h5b;

    // ****
    // limits
    // ****
    localparam logic [2:0] MESMQ_MARK_MAX = 3'h5;
    localparam logic [2:0] MESMQ_SPACE_MAX = 3'h4;
    localparam logic [1:0] MESMQ_CC_DEPTH = 2'h2;
    localparam logic [4:0] MESMQ_RESYNC_SAT = 5'h1f;

    // ****
    // window position codes
    // ****
    typedef enum logic [1:0] {
        MESMQ_WIN_NOMINAL = 2'b00,
        MESMQ_WIN_DELAYED = 2'b01,
        MESMQ_WIN_ADVANCED = 2'b10,
        MESMQ_WIN_RESERVED = 2'b11
    } mesmq_winpos_type;

endpackage : mesmq_pkg

// file: logic/mesmq_cc_stack.sv
// mesmq_cc_stack: two-deep stack behind the correction complete flag
`timescale 1ns/1ns
`default_nettype none
module mesmq_cc_stack (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link to top
    mesmq_link_if.cc lnk
);
    import mesmq_pkg::*;

    logic [1:0] cnt_r, cnt_nxt;
    logic gap_nxt;
    logic bit_r, bit_nxt;
    logic dec;

    // a clear or an auto clear retires one event; a new event lands unless the stack is full
    always_comb begin
        dec = (lnk.cc_clr || lnk.cc_auto) && cnt_r != 2'h0;
        cnt_nxt = cnt_r;
        gap_nxt = 1'b0;
        if (lnk.cc_flush) begin
            cnt_nxt = 2'h0;
        end else if (dec) begin
            cnt_nxt = cnt_r - 2'h1;
            // one low cycle so the stacked event shows as a fresh edge
            gap_nxt = (cnt_r == MESMQ_CC_DEPTH);
        end
        if (lnk.cc_set && cnt_nxt != MESMQ_CC_DEPTH) begin
            cnt_nxt = cnt_nxt + 2'h1;
        end
        bit_nxt = (cnt_nxt != 2'h0) && !gap_nxt;
    end

    // state registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 2'h0;
            bit_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
        end
    end

    assign lnk.cc_bit = bit_r;

endmodule : mesmq_cc_stack
`default_nettype wire

// file: logic/mesmq_mark_qual.sv
// mesmq_mark_qual: long mark and long space counting for sector mark voting
`timescale 1ns/1ns
`default_nettype none
module mesmq_mark_qual (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link to top
    mesmq_link_if.qual lnk
);
    import mesmq_pkg::*;

    logic [2:0] mk_sync_r, mk_sync_nxt;
    logic [2:0] sp_sync_r, sp_sync_nxt;
    logic mk_stable_r, mk_stable_nxt;
    logic sp_stable_r, sp_stable_nxt;
    logic [2:0] mk_cnt_r, mk_cnt_nxt;
    logic [2:0] sp_cnt_r, sp_cnt_nxt;
    logic qual_r, qual_nxt;
    logic [2:0] mthr;
    logic [2:0] sthr;

    // read channel levels: three flops, a change counts once 2nd and 3rd agree
    always_comb begin
        mk_sync_nxt = {mk_sync_r[1:0], lnk.long_mark_pin};
        sp_sync_nxt = {sp_sync_r[1:0], lnk.long_space_pin};
        mk_stable_nxt = mk_stable_r;
        sp_stable_nxt = sp_stable_r;
        if (mk_sync_r[2] == mk_sync_r[1]) begin
            mk_stable_nxt = mk_sync_r[2];
        end
        if (sp_sync_r[2] == sp_sync_r[1]) begin
            sp_stable_nxt = sp_sync_r[2];
        end
    end

    // thresholds above their range are held at the top of the range
    always_comb begin
        mthr = (lnk.mark_thr > MESMQ_MARK_MAX) ? MESMQ_MARK_MAX
            : lnk.mark_thr;
        sthr = (lnk.space_thr > MESMQ_SPACE_MAX) ? MESMQ_SPACE_MAX
            : lnk.space_thr;
    end

    // count rising edges of clean long marks and spaces, saturating
    always_comb begin
        mk_cnt_nxt = mk_cnt_r;
        sp_cnt_nxt = sp_cnt_r;
        qual_nxt = 1'b0;
        if (mk_stable_nxt && !mk_stable_r && mk_cnt_r != 3'h7) begin
            mk_cnt_nxt = mk_cnt_r + 3'h1;
        end
        if (sp_stable_nxt && !sp_stable_r && sp_cnt_r != 3'h7) begin
            sp_cnt_nxt = sp_cnt_r + 3'h1;
        end
        if (lnk.sm_cand) begin
            qual_nxt = (mk_cnt_r >= mthr) && (sp_cnt_r >= sthr);
            mk_cnt_nxt = 3'h0;
            sp_cnt_nxt = 3'h0;
        end
        if (lnk.sector_start) begin
            mk_cnt_nxt = 3'h0;
            sp_cnt_nxt = 3'h0;
        end
    end

    // state registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mk_sync_r <= 3'h0;
            sp_sync_r <= 3'h0;
            mk_stable_r <= 1'b0;
            sp_stable_r <= 1'b0;
            mk_cnt_r <= 3'h0;
            sp_cnt_r <= 3'h0;
            qual_r <= 1'b0;
        end else begin
            mk_sync_r <= mk_sync_nxt;
            sp_sync_r <= sp_sync_nxt;
            mk_stable_r <= mk_stable_nxt;
            sp_stable_r <= sp_stable_nxt;
            mk_cnt_r <= mk_cnt_nxt;
            sp_cnt_r <= sp_cnt_nxt;
            qual_r <= qual_nxt;
        end
    end

    assign lnk.sm_qualified = qual_r;

endmodule : mesmq_mark_qual
`default_nettype wire

// file: logic/mesmq_top.sv
// mesmq_top: media error flags and sector mark window and voting control
//
// Behaviour
// - bit 4: target found, sync mark missed, first resync syncs
// - bit 3: target found, no sync from mark or early resyncs
// - bit 2: missing or unsynced resyncs exceed threshold
// - bit 1: written flag field detected
// - bit 1 meaningless for 512-byte sectors on 90 mm media
// - bit 1 feeds pending only when its enable is set
// - writing one to bit 1 clears it
// - read: bit 0 sets per corrected sector; interrupt if enabled
// - two completions stack; second reasserts after clearing
// - interrupt off: bit 0 clears after next sector's redundancy
// - verify: bit 0 flags wrong blank or non-blank sector
// - verify: writing one to bit 0 clears it
// - window position: nominal, delayed, advanced, reserved
// - after sector mark or good ID, position ignored until next sector
// - long mark threshold 0 to 5 qualifies sector mark
// - long space threshold 0 to 4 qualifies sector mark
// - one clears a flag; one to pending bit clears all
`timescale 1ns/1ns
`default_nettype none
module mesmq_top (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // microcontroller register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic pend_clr_all,
    // operation configuration held elsewhere
    input wire logic op_after_flag_en,
    input wire logic cc_int_en,
    input wire logic fmt_512_90mm,
    input wire logic verify_op,
    input wire logic blank_verify,
    input wire logic [3:0] resync_thr,
    // sequencer and decoder events
    input wire logic sector_start,
    input wire logic target_found,
    input wire logic dsm_missed,
    input wire logic sync_first_resync,
    input wire logic sync_failed,
    input wire logic resync_missing,
    input wire logic resync_unsynced,
    input wire logic flag_written,
    input wire logic ecc_done,
    input wire logic redund_done,
    input wire logic verify_done,
    input wire logic sector_blank,
    input wire logic sm_detected,
    input wire logic id_good,
    input wire logic sm_cand,
    // read channel pins
    input wire logic long_mark_pin,
    input wire logic long_space_pin,
    // status and window outputs
    output logic media_pending,
    output logic cc_irq,
    output mesmq_pkg::mesmq_winpos_type win_pos,
    output logic win_referenced,
    output logic sm_qualified
);
    import mesmq_pkg::*;

    mesmq_link_if lnk ();

    logic [4:1] flags_r, flags_nxt;
    logic [7:0] smctl_r, smctl_nxt;
    logic [4:0] rs_cnt_r, rs_cnt_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic pend_r, pend_nxt;
    logic irq_r, irq_nxt;
    mesmq_winpos_type wpos_r, wpos_nxt;
    logic wref_r, wref_nxt;
    logic sq_r, sq_nxt;
    logic wr_media;
    logic [4:0] clr_mask;
    logic [4:0] set_mask;
    logic [4:0] flags_all;
    logic [1:0] rs_inc;
    logic [4:0] rs_sum;

    // ****
    // helper modules
    // ****

    mesmq_mark_qual u_qual (
        .clk(clk),
        .reset_n(reset_n),
        .lnk(lnk)
    );

    mesmq_cc_stack u_cc (
        .clk(clk),
        .reset_n(reset_n),
        .lnk(lnk)
    );

    // ****
    // flag set and clear terms
    // ****

    // write one clears a flag, the pending bit write clears every flag
    always_comb begin
        wr_media = reg_wr && (reg_addr == MESMQ_ADDR_MEDIA_ERR);
        clr_mask = 5'h00;
        if (wr_media) begin
            clr_mask = reg_wdata[4:0];
        end
        if (pend_clr_all) begin
            clr_mask = 5'h1f;
        end
    end

    // resync errors of this sector; two events in a cycle both count
    always_comb begin
        rs_inc = {1'b0, resync_missing} + {1'b0, resync_unsynced};
        rs_sum = rs_cnt_r + {3'h0, rs_inc};
        if (rs_sum < rs_cnt_r) begin
            rs_sum = MESMQ_RESYNC_SAT;
        end
        rs_cnt_nxt = sector_start ? 5'h00 : rs_sum;
    end

    // events that raise each flag
    always_comb begin
        set_mask = 5'h00;
        set_mask[MESMQ_BIT_DSYNC_RECOV] = target_found && dsm_missed
            && sync_first_resync;
        set_mask[MESMQ_BIT_DSYNC_FATAL] = target_found
            && sync_failed;
        set_mask[MESMQ_BIT_RESYNC_THR] = rs_cnt_r > {1'b0, resync_thr};
        // the flag field is not defined on this format, so it never sets
        set_mask[MESMQ_BIT_FLAG_FIELD] = flag_written
            && !fmt_512_90mm;
        set_mask[MESMQ_BIT_CC_BLANK] = verify_op
            ? (verify_done && (blank_verify ^ sector_blank))
            : ecc_done;
    end

    // set wins over clear, so an event in the clearing cycle is kept
    always_comb begin
        flags_nxt = (flags_r & ~clr_mask[4:1]) | set_mask[4:1];
    end

    // ****
    // correction complete / blank error stack
    // ****

    // the stack drops one entry per clear; auto clear only when irq is off
    always_comb begin
        lnk.cc_set = set_mask[MESMQ_BIT_CC_BLANK];
        lnk.cc_clr = wr_media && reg_wdata[MESMQ_BIT_CC_BLANK];
        lnk.cc_flush = pend_clr_all;
        lnk.cc_auto = redund_done && !cc_int_en && !verify_op;
    end

    assign flags_all = {flags_r, lnk.cc_bit};

    // ****
    // pending summary and interrupt
    // ****

    // the flag field bit only counts toward pending when allowed
    always_comb begin
        pend_nxt = flags_nxt[MESMQ_BIT_DSYNC_RECOV]
                 || flags_nxt[MESMQ_BIT_DSYNC_FATAL]
                 || flags_nxt[MESMQ_BIT_RESYNC_THR]
                 || (flags_nxt[MESMQ_BIT_FLAG_FIELD]
                     && op_after_flag_en)
                 || lnk.cc_bit;
        irq_nxt = lnk.cc_bit && cc_int_en && !verify_op;
    end

    // ****
    // sector mark control register
    // ****

    // plain read/write byte; its fields steer the window and voting
    always_comb begin
        smctl_nxt = smctl_r;
        if (reg_wr && reg_addr == MESMQ_ADDR_SM_CTRL) begin
            smctl_nxt = reg_wdata;
        end
        lnk.mark_thr = smctl_r[MESMQ_MTHR_HI:MESMQ_MTHR_LO];
        lnk.space_thr = smctl_r[MESMQ_STHR_HI:MESMQ_STHR_LO];
        lnk.sector_start = sector_start;
        lnk.sm_cand = sm_cand;
        lnk.long_mark_pin = long_mark_pin;
        lnk.long_space_pin = long_space_pin;
    end

    // ****
    // window position tracking
    // ****

    // position is sampled at sector start and frozen once referenced;
    // the reserved code falls back to nominal rather than guessing
    always_comb begin
        wpos_nxt = wpos_r;
        wref_nxt = wref_r;
        if (sector_start) begin
            wref_nxt = 1'b0;
            wpos_nxt = mesmq_winpos_type'(smctl_r[MESMQ_WPOS_HI:MESMQ_WPOS_LO]);
            if (wpos_nxt == MESMQ_WIN_RESERVED) begin
                wpos_nxt = MESMQ_WIN_NOMINAL;
            end
        end
        if (sm_detected || id_good) begin
            wref_nxt = 1'b1;
        end
        sq_nxt = lnk.sm_qualified;
    end

    // ****
    // register read data
    // ****

    // unmapped addresses and unused high bits read as zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                MESMQ_ADDR_MEDIA_ERR: rdata_nxt = {3'h0, flags_all};
                MESMQ_ADDR_SM_CTRL: rdata_nxt = smctl_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // ****
    // state registers
    // ****

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_r <= MESMQ_FLAGS_RST[4:1];
            smctl_r <= MESMQ_SM_CTRL_RST;
            rs_cnt_r <= 5'h00;
            rdata_r <= 8'h00;
            pend_r <= 1'b0;
            irq_r <= 1'b0;
            wpos_r <= MESMQ_WIN_NOMINAL;
            wref_r <= 1'b0;
            sq_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            smctl_r <= smctl_nxt;
            rs_cnt_r <= rs_cnt_nxt;
            rdata_r <= rdata_nxt;
            pend_r <= pend_nxt;
            irq_r <= irq_nxt;
            wpos_r <= wpos_nxt;
            wref_r <= wref_nxt;
            sq_r <= sq_nxt;
        end
    end

    // every output leaves from a flop
    assign reg_rdata = rdata_r;
    assign media_pending = pend_r;
    assign cc_irq = irq_r;
    assign win_pos = wpos_r;
    assign win_referenced = wref_r;
    assign sm_qualified = sq_r;

endmodule : mesmq_top
`default_nettype wire

// file: verification/mesmq_chan_model.sv
// mesmq_chan_model: read channel giving long mark and long space pulses
`timescale 1ns/1ns
`default_nettype none
module mesmq_chan_model (
    // clock
    input wire logic clk,
    // command from bench
    input wire logic go,
    input wire logic [2:0] n_mark,
    input wire logic [2:0] n_space,
    output logic busy,
    // read channel pins
    output logic long_mark_pin,
    output logic long_space_pin
);
    // pins idle low; six-cycle pulses leave room for the synchroniser
    initial begin
        busy = 1'b0;
        long_mark_pin = 1'b0;
        long_space_pin = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                for (int i = 0; i < 5; i++) begin
                    long_mark_pin <= (i < n_mark);
                    repeat (6) @(posedge clk);
                    long_mark_pin <= 1'b0;
                    long_space_pin <= (i < n_space);
                    repeat (6) @(posedge clk);
                    long_space_pin <= 1'b0;
                    repeat (6) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule : mesmq_chan_model
`default_nettype wire

// file: verification/mesmq_top_monitor.sv
// mesmq_top_monitor: port-level assertions for mesmq_top
`timescale 1ns/1ns
`default_nettype none
module mesmq_top_monitor
    import mesmq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // inputs watched
    input wire logic reg_wr,
    input wire logic pend_clr_all,
    input wire logic cc_int_en,
    input wire logic verify_op,
    input wire logic target_found,
    input wire logic dsm_missed,
    input wire logic sync_first_resync,
    input wire logic sync_failed,
    input wire logic ecc_done,
    input wire logic sector_start,
    input wire logic sm_detected,
    input wire logic id_good,
    input wire logic sm_cand,
    // outputs watched
    input wire logic media_pending,
    input wire logic cc_irq,
    input wire mesmq_pkg::mesmq_winpos_type win_pos,
    input wire logic win_referenced,
    input wire logic sm_qualified
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ****************
    // flag summary
    // ****************
    AST_RECOV_PEND: assert property (
        target_found && dsm_missed && sync_first_resync
        |-> ##[1:2] media_pending) else $error("recovered sync not pending");
    AST_FATAL_PEND: assert property (
        target_found && sync_failed |-> ##[1:2] media_pending)
        else $error("fatal sync not pending");
    // interrupt only from read mode with its enable
    AST_IRQ_GATE: assert property (
        cc_irq |-> $past(cc_int_en) && !$past(verify_op))
        else $error("irq without enable");
    AST_IRQ_RAISE: assert property (
        ecc_done && cc_int_en && !verify_op ##1
        cc_int_en && !verify_op && !reg_wr && !pend_clr_all |=> cc_irq)
        else $error("irq late after completion");

    // ****************
    // window and mark
    // ****************
    AST_WIN_CODE: assert property (
        win_pos != MESMQ_WIN_RESERVED) else $error("reserved window code");
    AST_WIN_REF: assert property (
        (sm_detected || id_good) && !sector_start |=> win_referenced)
        else $error("window not referenced");
    AST_WIN_CLR: assert property (
        sector_start && !sm_detected && !id_good |=> !win_referenced)
        else $error("reference not dropped");
    AST_WIN_HOLD: assert property (
        win_referenced && !sector_start |=> $stable(win_pos))
        else $error("window moved while referenced");
    AST_SMQ_CAUSE: assert property (
        sm_qualified |-> $past(sm_cand, 2))
        else $error("qualify without candidate");
    AST_SMQ_PULSE: assert property (
        sm_qualified && !$past(sm_cand) |=> !sm_qualified)
        else $error("qualify pulse too long");

    // restacked completion, qualified mark, referenced window
    cover property (cc_irq ##1 !cc_irq ##1 cc_irq);
    cover property (sm_qualified);
    cover property (win_referenced && sector_start);
endmodule : mesmq_top_monitor

bind mesmq_top mesmq_top_monitor u_mon (
    .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .pend_clr_all(pend_clr_all), .cc_int_en(cc_int_en),
    .verify_op(verify_op), .target_found(target_found),
    .dsm_missed(dsm_missed), .sync_first_resync(sync_first_resync),
    .sync_failed(sync_failed), .ecc_done(ecc_done),
    .sector_start(sector_start), .sm_detected(sm_detected),
    .id_good(id_good), .sm_cand(sm_cand), .media_pending(media_pending),
    .cc_irq(cc_irq), .win_pos(win_pos), .win_referenced(win_referenced),
    .sm_qualified(sm_qualified)
);
`default_nettype wire

// file: verification/mesmq_top_tb.sv
// mesmq_top_tb: self-checking bench for flags and sector mark control
`timescale 1ns/1ns
`default_nettype none
module mesmq_top_tb;
    import mesmq_pkg::*;
    logic clk, reset_n, reg_wr, reg_rd, pend_clr_all, op_after_flag_en;
    logic cc_int_en, fmt_512_90mm, verify_op, blank_verify, sector_blank;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [3:0] resync_thr;
    // event order: sector_start, target_found, dsm_missed, first resync,
    // sync_failed, resync missing, unsynced, flag_written, ecc_done,
    // redund_done, verify_done, sm_detected, id_good, sm_cand
    logic [13:0] ev;
    logic media_pending, cc_irq, win_referenced, sm_qualified;
    logic long_mark_pin, long_space_pin, chan_go, chan_busy, rd_d;
    logic [2:0] n_mark, n_space;
    mesmq_winpos_type win_pos;
    logic [7:0] exp_q[$];
    int n_errors, checks, seed, thr, c0;
    int sm_cnt = 0;
    int cm[5] = '{3, 2, 3, 5, 0};
    int cs[5] = '{3, 3, 2, 4, 0};
    int tm[5] = '{3, 3, 3, 5, 0};
    int ts[5] = '{3, 3, 3, 4, 0};
    int sq[5] = '{1, 0, 0, 1, 1};

    mesmq_top u_dut (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .pend_clr_all(pend_clr_all),
        .op_after_flag_en(op_after_flag_en), .cc_int_en(cc_int_en),
        .fmt_512_90mm(fmt_512_90mm), .verify_op(verify_op),
        .blank_verify(blank_verify), .resync_thr(resync_thr),
        .sector_start(ev[0]), .target_found(ev[1]), .dsm_missed(ev[2]),
        .sync_first_resync(ev[3]), .sync_failed(ev[4]),
        .resync_missing(ev[5]), .resync_unsynced(ev[6]),
        .flag_written(ev[7]), .ecc_done(ev[8]), .redund_done(ev[9]),
        .verify_done(ev[10]), .sector_blank(sector_blank),
        .sm_detected(ev[11]), .id_good(ev[12]), .sm_cand(ev[13]),
        .long_mark_pin(long_mark_pin), .long_space_pin(long_space_pin),
        .media_pending(media_pending), .cc_irq(cc_irq),
        .win_pos(win_pos), .win_referenced(win_referenced),
        .sm_qualified(sm_qualified)
    );
    mesmq_chan_model u_chan (
        .clk(clk), .go(chan_go), .n_mark(n_mark), .n_space(n_space),
        .busy(chan_busy), .long_mark_pin(long_mark_pin),
        .long_space_pin(long_space_pin)
    );

    // ****************
    // tasks
    // ****************
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
        checks++;
        if (seen !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, e, seen);
        end
    endtask : chk
    task end_sim;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // one-cycle events; the idle edge after keeps ev single-driven
    task fire(input logic [13:0] m);
        ev <= m;
        @(posedge clk);
        ev <= 14'h0000;
        @(posedge clk);
    endtask : fire
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    // the expected byte waits in exp_q for the read monitor
    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask : rd
    task wait_idle;
        int k;
        k = 0;
        while (chan_busy && k < 500) begin
            @(posedge clk);
            k++;
        end
        if (chan_busy) begin
            n_errors++;
            end_sim;
        end
    endtask : wait_idle

    // ****************
    // clock and monitors
    // ****************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // read data lands one cycle after the strobe edge
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (sm_qualified === 1'b1) begin
            sm_cnt <= sm_cnt + 1;
        end
        if (rd_d && exp_q.size() == 0) begin
            chk("read queue", 8'h01, 8'h00);
        end else if (rd_d) begin
            chk("reg_rdata", reg_rdata, exp_q.pop_front());
        end
    end

    // ****************
    // stimulus
    // ****************
    initial begin
        seed = 32'h1b373df2;
        n_errors = 0;
        checks = 0;
        reset_n = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, pend_clr_all} = '0;
        {op_after_flag_en, cc_int_en, fmt_512_90mm, verify_op} = '0;
        {blank_verify, sector_blank, ev, chan_go, n_mark, n_space} = '0;
        resync_thr = 4'h0;
        tick(20);
        reset_n <= 1'b1;
        tick(1);
        rd(8'h24, MESMQ_SM_CTRL_RST);
        rd(8'h23, 8'h00);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        v = {2'($random(seed)), 3'($unsigned($random(seed)) % 6),
            3'($unsigned($random(seed)) % 5)};
        wr(8'h24, v);
        rd(8'h24, v);
        fire(14'h000e);
        rd(8'h23, 8'h10);
        wr(8'h23, 8'h00);
        rd(8'h23, 8'h10);
        wr(8'h23, 8'h10);
        rd(8'h23, 8'h00);
        fire(14'h0012);
        rd(8'h23, 8'h08);
        pend_clr_all <= 1'b1;
        tick(1);
        pend_clr_all <= 1'b0;
        tick(1);
        rd(8'h23, 8'h00);
        // random threshold: exactly thr errors stay quiet
        thr = 1 + $unsigned($random(seed)) % 4;
        resync_thr <= 4'(thr);
        fire(14'h0001);
        for (int k = 0; k < thr; k++) begin
            fire(k[0] ? 14'h0040 : 14'h0020);
        end
        tick(2);
        rd(8'h23, 8'h00);
        fire(14'h0040);
        tick(2);
        rd(8'h23, 8'h04);
        // a new sector drops the count, else the flag sets again
        fire(14'h0001);
        wr(8'h23, 8'h04);
        fmt_512_90mm <= 1'b1;
        fire(14'h0080);
        rd(8'h23, 8'h00);
        fmt_512_90mm <= 1'b0;
        fire(14'h0080);
        rd(8'h23, 8'h02);
        chk("media_pending", 8'(media_pending), 8'h00);
        op_after_flag_en <= 1'b1;
        tick(3);
        chk("media_pending", 8'(media_pending), 8'h01);
        wr(8'h23, 8'h02);
        rd(8'h23, 8'h00);
        // three completions: two stack, the third is lost
        cc_int_en <= 1'b1;
        repeat (3) fire(14'h0100);
        tick(2);
        chk("cc_irq", 8'(cc_irq), 8'h01);
        wr(8'h23, 8'h01);
        rd(8'h23, 8'h01);
        wr(8'h23, 8'h01);
        rd(8'h23, 8'h00);
        chk("cc_irq", 8'(cc_irq), 8'h00);
        cc_int_en <= 1'b0;
        fire(14'h0100);
        rd(8'h23, 8'h01);
        fire(14'h0200);
        rd(8'h23, 8'h00);
        verify_op <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            blank_verify <= b[1];
            sector_blank <= b[0];
            fire(14'h0400);
            rd(8'h23, {7'h00, b[1] ^ b[0]});
            wr(8'h23, 8'h01);
            rd(8'h23, 8'h00);
        end
        verify_op <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            wr(8'h24, {2'b01, 3'(tm[i]), 3'(ts[i])});
            fire(14'h0001);
            n_mark <= 3'(cm[i]);
            n_space <= 3'(cs[i]);
            chan_go <= 1'b1;
            tick(1);
            chan_go <= 1'b0;
            tick(2);
            wait_idle;
            tick(8);
            c0 = sm_cnt;
            fire(14'h2000);
            tick(2);
            chk("sm_qualified", 8'(sm_cnt - c0), 8'(sq[i]));
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h24, {2'(c), 6'h1b});
            fire(14'h0001);
            tick(1);
            chk("win_pos", 8'(win_pos), (c == 3) ? 8'h00 : 8'(c));
        end
        // once referenced, a new position waits for the next sector
        wr(8'h24, 8'h9b);
        fire(14'h0001);
        fire(14'h1000);
        chk("win_referenced", 8'(win_referenced), 8'h01);
        wr(8'h24, 8'h5b);
        tick(1);
        chk("win_pos", 8'(win_pos), 8'h02);
        fire(14'h0001);
        tick(1);
        chk("win_pos", 8'(win_pos), 8'h01);
        chk("win_referenced", 8'(win_referenced), 8'h00);
        fire(14'h0800);
        chk("win_referenced", 8'(win_referenced), 8'h01);
        tick(4);
        end_sim;
    end
endmodule : mesmq_top_tb
`default_nettype wire
